// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import uifc_pkg::*;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'h0;
   logic regRead = 1'h0;
   logic pushRx = 1'h0;
   logic modemChange = 1'h0;
   logic enhancedEnable = 1'h0;
   logic intDriveEnable = 1'h0;
   logic autoFlow = 1'h0;
   logic ctsPin_n = 1'h0;
   logic rxHoldFull = 1'h0;
   logic [4:0] ev = 5'h00;
   logic [3:0] errs = 4'h0;
   logic [7:0] regRdData, modemStatus;
   logic [4:0] rxFifoCount, txFifoCount;
   logic [1:0] rxTrigCode, txTrigCode;
   logic rxCharArrived, txHoldEmpty, txShiftEmpty, bitTick, rxHoldRead, modemStatusRead;
   logic rxFifoReset, txFifoReset, fifoEnabled, dmaMode, sleepEnable, polledMode, irqOut;
   logic irqOutEnable_n, txHoldWrite;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   always #50 clock = ~clock;
   uifc_irq_fifo_ctrl i_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .rxFifoCount(rxFifoCount), .rxHoldFull(rxHoldFull), .rxCharArrived(rxCharArrived),
      .rxOverrun(ev[0]), .frontParityError(errs[0]), .frontFramingError(errs[1]),
      .frontBreak(errs[2]), .rxFifoAnyError(errs[3]), .bitTick(bitTick), .charBits(4'h8),
      .txFifoCount(txFifoCount), .txHoldEmpty(txHoldEmpty), .txShiftEmpty(txShiftEmpty),
      .modemStatus(modemStatus), .xoffMatch(ev[4]), .specialMatch(ev[3]), .xonMatch(ev[2]),
      .rtsRise(ev[1]), .ctsPin_n(ctsPin_n), .autoCtsEnable(autoFlow), .autoRtsEnable(autoFlow),
      .enhancedEnable(enhancedEnable), .intDriveEnable(intDriveEnable),
      .rxHoldRead(rxHoldRead), .txHoldWrite(txHoldWrite), .modemStatusRead(modemStatusRead),
      .rxFifoReset(rxFifoReset), .txFifoReset(txFifoReset), .fifoEnabled(fifoEnabled),
      .dmaMode(dmaMode), .rxTrigCode(rxTrigCode), .txTrigCode(txTrigCode),
      .sleepEnable(sleepEnable), .polledMode(polledMode), .irqOut(irqOut),
      .irqOutEnable_n(irqOutEnable_n));
   uifc_far_model i_far (.clock(clock), .rst_n(rst_n), .pushRx(pushRx),
      .modemChange(modemChange), .rxHoldRead(rxHoldRead), .rxFifoReset(rxFifoReset),
      .modemStatusRead(modemStatusRead), .rxFifoCount(rxFifoCount),
      .rxCharArrived(rxCharArrived), .txFifoCount(txFifoCount), .txHoldEmpty(txHoldEmpty),
      .txShiftEmpty(txShiftEmpty), .modemStatus(modemStatus), .bitTick(bitTick));
   ////////////////////////////////////////
   task automatic end_sim();
      if (errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clock);
      regAddr <= a;
      regWrData <= v;
      regWrite <= 1'h1;
      @(posedge clock);
      regWrite <= 1'h0;
      #1;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge clock);
      regRead <= 1'h0;
      #1 chk(regRdData, exp);
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge clock);
      ev <= v;
      @(posedge clock);
      ev <= 5'h00;
      repeat (2) @(posedge clock);
   endtask
   task automatic push(input int n);
      repeat (n) begin
         @(posedge clock);
         pushRx <= 1'h1;
         @(posedge clock);
         pushRx <= 1'h0;
      end
      @(posedge clock);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rd(OFS_INT_STATUS, 8'h01);
      rd(OFS_INT_ENABLE, 8'h00);
      rd(3'h3, 8'h00);
      chk({6'h00, irqOut, irqOutEnable_n}, 8'h01);
   endtask
   task automatic t_enable();
      wr(OFS_INT_ENABLE, 8'hFF);
      rd(OFS_INT_ENABLE, 8'h0F);
      @(posedge clock) rxHoldFull <= 1'h1;
      rd(OFS_INT_STATUS, 8'h04);
      @(posedge clock) rxHoldFull <= 1'h0;
      @(posedge clock) enhancedEnable <= 1'h1;
      wr(OFS_INT_ENABLE, 8'hF0);
      rd(OFS_INT_ENABLE, 8'hF0);
      chk({7'h00, sleepEnable}, 8'h01);
      wr(OFS_INT_ENABLE, 8'h00);
   endtask
   task automatic t_fifo();
      @(posedge clock) enhancedEnable <= 1'h0;
      wr(OFS_FIFO_CONTROL, 8'hF7);
      chk({rxTrigCode, txTrigCode, rxFifoReset, txFifoReset, fifoEnabled, dmaMode}, 8'hCE);
      wr(OFS_FIFO_CONTROL, 8'h3A);
      chk({rxTrigCode, txTrigCode, rxFifoReset, txFifoReset, fifoEnabled, dmaMode}, 8'hC0);
      rd(OFS_INT_STATUS, 8'h01);
      @(posedge clock) enhancedEnable <= 1'h1;
      wr(OFS_FIFO_CONTROL, 8'h39);
      chk({rxTrigCode, txTrigCode, rxFifoReset, txFifoReset, fifoEnabled, dmaMode}, 8'h33);
      rd(OFS_INT_STATUS, 8'hC1);
      chk({7'h00, polledMode}, 8'h01);
   endtask
   task automatic t_rx();
      logic [4:0] lvl [4];
      lvl = '{5'h01, 5'h04, 5'h08, 5'h0E};
      wr(OFS_INT_ENABLE, 8'h01);
      chk({7'h00, polledMode}, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_FIFO_CONTROL, {c[1:0], 6'h03});
         push(lvl[c] - 5'h01);
         rd(OFS_INT_STATUS, 8'hC1);
         push(1);
         rd(OFS_INT_STATUS, 8'hC4);
         rd(OFS_DATA, 8'h00);
         rd(OFS_INT_STATUS, 8'hC1);
      end
   endtask
   // must finish well inside one time-out span after the push
   task automatic t_line();
      wr(OFS_FIFO_CONTROL, 8'h03);
      push(1);
      wr(OFS_INT_ENABLE, 8'h05);
      pulse(5'h01);
      rd(OFS_INT_STATUS, 8'hC6);
      rd(OFS_LINE_STATUS, 8'h63);
      rd(OFS_INT_STATUS, 8'hC4);
      @(posedge clock) errs <= 4'hF;
      rd(OFS_INT_STATUS, 8'hC6);
      rd(OFS_LINE_STATUS, 8'hFD);
      rd(OFS_INT_STATUS, 8'hC4);
      @(posedge clock) errs <= 4'h0;
   endtask
   task automatic t_timeout();
      int n;
      wr(OFS_FIFO_CONTROL, 8'h43);
      wr(OFS_INT_ENABLE, 8'h01);
      @(posedge clock) intDriveEnable <= 1'h1;
      push(1);
      n = 0;
      #1;
      while (irqOut !== 1'h1 && n < 200) begin
         #100;
         n++;
      end
      chk({7'h00, n >= 84 && n <= 100}, 8'h01);
      chk({6'h00, irqOut, irqOutEnable_n}, 8'h02);
      rd(OFS_INT_STATUS, 8'hCC);
      rd(OFS_DATA, 8'h00);
      rd(OFS_INT_STATUS, 8'hC1);
   endtask
   task automatic t_tx();
      wr(OFS_DATA, 8'h00);
      chk({7'h00, txHoldWrite}, 8'h01);
      wr(OFS_INT_ENABLE, 8'h02);
      repeat (2) @(posedge clock);
      #1 chk({7'h00, irqOut}, 8'h01);
      rd(OFS_INT_STATUS, 8'hC2);
      rd(OFS_INT_STATUS, 8'hC1);
   endtask
   task automatic t_modem();
      wr(OFS_INT_ENABLE, 8'h08);
      @(posedge clock) modemChange <= 1'h1;
      @(posedge clock) modemChange <= 1'h0;
      rd(OFS_INT_STATUS, 8'hC0);
      rd(OFS_INT_STATUS, 8'hC0);
      rd(OFS_MODEM_STATUS, 8'hB1);
      rd(OFS_INT_STATUS, 8'hC1);
   endtask
   task automatic t_flow();
      wr(OFS_INT_ENABLE, 8'h20);
      pulse(5'h10);
      rd(OFS_INT_STATUS, 8'hD0);
      rd(OFS_INT_STATUS, 8'hC1);
      pulse(5'h10);
      pulse(5'h04);
      rd(OFS_INT_STATUS, 8'hC1);
      pulse(5'h08);
      #1 chk({7'h00, irqOut}, 8'h01);
      push(1);
      rd(OFS_INT_STATUS, 8'hC1);
      wr(OFS_INT_ENABLE, 8'h40);
      @(posedge clock) autoFlow <= 1'h1;
      pulse(5'h02);
      rd(OFS_INT_STATUS, 8'hE0);
      rd(OFS_MODEM_STATUS, 8'hB0);
      rd(OFS_INT_STATUS, 8'hC1);
      wr(OFS_INT_ENABLE, 8'h80);
      @(posedge clock) ctsPin_n <= 1'h1;
      repeat (8) @(posedge clock);
      rd(OFS_INT_STATUS, 8'hE0);
      rd(OFS_MODEM_STATUS, 8'hB0);
      rd(OFS_INT_STATUS, 8'hC1);
   endtask
   ////////////////////////////////////////
   // the whole sequence needs under two thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'h1;
      t_reset();
      t_enable();
      t_fifo();
      t_rx();
      t_line();
      t_timeout();
      t_tx();
      t_modem();
      t_flow();
      end_sim();
   end
endmodule // testbench
`default_nettype wire

// ===== uifc_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module uifc_far_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bench commands
   input wire logic pushRx,
   input wire logic modemChange,
   // strobes from the block
   input wire logic rxHoldRead,
   input wire logic rxFifoReset,
   input wire logic modemStatusRead,
   // datapath view
   output logic [4:0] rxFifoCount,
   output logic rxCharArrived,
   output logic [4:0] txFifoCount,
   output logic txHoldEmpty,
   output logic txShiftEmpty,
   output logic [7:0] modemStatus,
   output var logic bitTick
);
   // transmitter kept idle: nothing is ever queued for it
   assign txFifoCount = 5'h00;
   assign txHoldEmpty = 1'h1;
   assign txShiftEmpty = 1'h1;
   ////////////////////////////////////////
   // pointer reset wins over a push landing in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rxFifoCount <= 5'h00;
         rxCharArrived <= 1'h0;
      end else begin
         rxCharArrived <= pushRx;
         if (rxFifoReset) begin
            rxFifoCount <= 5'h00;
         end else if (pushRx && rxFifoCount != 5'h10) begin
            rxFifoCount <= rxFifoCount + 5'h01;
         end else if (rxHoldRead && rxFifoCount != 5'h00) begin
            rxFifoCount <= rxFifoCount - 5'h01;
         end
      end
   end
   ////////////////////////////////////////
   // change flag latches until the host reads modem status
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         modemStatus <= 8'hB0;
      end else if (modemChange) begin
         modemStatus <= 8'hB1;
      end else if (modemStatusRead) begin
         modemStatus <= 8'hB0;
      end
   end
   ////////////////////////////////////////
   // a bit time of two clocks keeps the time-out short
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bitTick <= 1'h0;
      end else begin
         bitTick <= !bitTick;
      end
   end
endmodule // uifc_far_model
`default_nettype wire

// ===== uifc_irq_fifo_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - FIFOs on and enables 0-3 clear gives polled mode, status still readable.
// - line_status shows data, overrun, front errors, holding empty, all empty, FIFO error.
// - receive enable raises receive interrupt on held character or trigger level.
// - transmit enable raises interrupt on empty or below trigger, also at enabling.
// - overrun interrupts at arrival, front-byte errors when that byte reaches the front.
// - modem enable interrupts while any modem change bit is set.
// - enables 4-7 writable only with enhanced functions; all reset to zero.
// - RTS interrupt on each automatic RTS low-to-high transition.
// - CTS interrupt on each remote low-to-high CTS edge under automatic CTS.
// - time-out interrupt after four characters plus twelve bits with data waiting.
// - status read returns only the highest pending source.
// - source codes follow the fixed priority table; none reads 000001.
// - each source clears by its own read, write or drain condition.
// - Xoff clears on status read or Xon, special on status read or next character; flow on modem read.
// - status bit 0 is low while anything pends, high otherwise and after reset.
// - status bits 7:6 both follow FIFO enable.
// - status bits 4 and 5 only active with enhanced functions.
// - FIFO enable bit gates every other bit of the same write.
// - FIFO reset bits pulse the pointer resets and self-clear.
// - DMA select bit steers the ready pins' mode.
// - transmit trigger 1/4/8/14, enhanced only, fires below level or on empty.
// - receive trigger 1/4/8/14, default 1, fires when count crosses the level.
// - interrupt pin driven only while the output-enable control bit is set.
module uifc_irq_fifo_ctrl (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // host register port
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // receive side
   input wire logic [4:0] rxFifoCount,
   input wire logic rxHoldFull,
   input wire logic rxCharArrived,
   input wire logic rxOverrun,
   input wire logic frontParityError,
   input wire logic frontFramingError,
   input wire logic frontBreak,
   input wire logic rxFifoAnyError,
   input wire logic bitTick,
   input wire logic [3:0] charBits,
   // transmit side
   input wire logic [4:0] txFifoCount,
   input wire logic txHoldEmpty,
   input wire logic txShiftEmpty,
   // modem and flow control
   input wire logic [7:0] modemStatus,
   input wire logic xoffMatch,
   input wire logic specialMatch,
   input wire logic xonMatch,
   input wire logic rtsRise,
   input wire logic ctsPin_n,
   input wire logic autoCtsEnable,
   input wire logic autoRtsEnable,
   input wire logic enhancedEnable,
   input wire logic intDriveEnable,
   // strobes to the datapath
   output logic rxHoldRead,
   output logic txHoldWrite,
   output logic modemStatusRead,
   output logic rxFifoReset,
   output logic txFifoReset,
   // configuration
   output logic fifoEnabled,
   output logic dmaMode,
   output logic [1:0] rxTrigCode,
   output logic [1:0] txTrigCode,
   output logic sleepEnable,
   output logic polledMode,
   // interrupt pin
   output logic irqOut,
   output logic irqOutEnable_n
);
   import uifc_pkg::*;

   function automatic uifc_src_t pick_source(input logic [6:0] req);
      if (req[0]) pick_source = UIFC_SRC_LINE;
      else if (req[1]) pick_source = UIFC_SRC_TIMEOUT;
      else if (req[2]) pick_source = UIFC_SRC_RX_READY;
      else if (req[3]) pick_source = UIFC_SRC_TX_READY;
      else if (req[4]) pick_source = UIFC_SRC_MODEM;
      else if (req[5]) pick_source = UIFC_SRC_XOFF;
      else if (req[6]) pick_source = UIFC_SRC_FLOW;
      else pick_source = UIFC_SRC_NONE;
   endfunction

   logic [7:0] intEnable;
   logic overrunFlag, lsrPend, frontErrQ, timeoutPend, txPend, xoffPend, specialPend;
   logic rtsPend, ctsPend, ctsSync1, ctsSync2, ctsSync3, ctsStable, ctsStableQ;
   logic [4:0] txCountQ;
   logic txHoldEmptyQ, reachedTrig, timeoutExpire;
   logic wrIer, wrFcr, wrData, rdIsr, rdLsr, rdMsr, rdData;
   logic dataPresent, frontErr, txEmptyNow, rxLevel, txSet, lineSet, ctsRise;
   logic [4:0] rxTrig, txTrig;
   logic [6:0] req;
   uifc_src_t currentSrc;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   // decode
   always_comb begin
      wrIer = 1'b0;
      wrFcr = 1'b0;
      wrData = 1'b0;
      if (regWrite) begin
         if (regAddr == OFS_INT_ENABLE) wrIer = 1'b1;
         else if (regAddr == OFS_FIFO_CONTROL) wrFcr = 1'b1;
         else if (regAddr == OFS_DATA) wrData = 1'b1;
      end
   end

   always_comb begin
      rdIsr = 1'b0;
      rdLsr = 1'b0;
      rdMsr = 1'b0;
      rdData = 1'b0;
      if (regRead) begin
         if (regAddr == OFS_INT_STATUS) rdIsr = 1'b1;
         else if (regAddr == OFS_LINE_STATUS) rdLsr = 1'b1;
         else if (regAddr == OFS_MODEM_STATUS) rdMsr = 1'b1;
         else if (regAddr == OFS_DATA) rdData = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         intEnable <= INT_ENABLE_RESET;
      end else if (wrIer) begin
         intEnable[3:0] <= regWrData[3:0];
         if (enhancedEnable) intEnable[7:4] <= regWrData[7:4];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fifoEnabled <= 1'b0;
         dmaMode <= 1'b0;
         rxTrigCode <= TRIG_CODE_RESET;
         txTrigCode <= TRIG_CODE_RESET;
      end else if (wrFcr) begin
         fifoEnabled <= regWrData[FC_ENABLE];
         if (regWrData[FC_ENABLE]) begin
            dmaMode <= regWrData[FC_DMA];
            rxTrigCode <= regWrData[7:6];
            if (enhancedEnable) txTrigCode <= regWrData[5:4];
         end
      end
   end

   // pointer resets are single pulses, so the bits clear themselves one cycle after the write
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rxFifoReset <= 1'b0;
         txFifoReset <= 1'b0;
      end else begin
         rxFifoReset <= wrFcr && regWrData[FC_ENABLE] && regWrData[FC_RX_RESET];
         txFifoReset <= wrFcr && regWrData[FC_ENABLE] && regWrData[FC_TX_RESET];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rxHoldRead <= 1'b0;
         txHoldWrite <= 1'b0;
         modemStatusRead <= 1'b0;
      end else begin
         rxHoldRead <= rdData;
         txHoldWrite <= wrData;
         modemStatusRead <= rdMsr;
      end
   end

   assign sleepEnable = intEnable[IE_SLEEP];
   assign polledMode = fifoEnabled && (intEnable[3:0] == 4'h0);
   assign rxTrig = uifc_trig_level(rxTrigCode);
   assign txTrig = uifc_trig_level(txTrigCode);

   ////////////////////////////////////////////////////////////////////////////
   // line status
   assign dataPresent = fifoEnabled ? (rxFifoCount != FIFO_EMPTY) : rxHoldFull;
   assign frontErr = dataPresent && (frontParityError || frontFramingError || frontBreak);
   assign txEmptyNow = fifoEnabled ? (txFifoCount == FIFO_EMPTY) : txHoldEmpty;
   assign lineSet = rxOverrun || (frontErr && !frontErrQ);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         overrunFlag <= 1'b0;
         frontErrQ <= 1'b0;
      end else begin
         frontErrQ <= frontErr;
         if (rxOverrun) overrunFlag <= 1'b1;
         else if (rdLsr) overrunFlag <= 1'b0;
      end
   end

   // errors of the front byte only count once that byte is at the front
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lsrPend <= 1'b0;
      end else if (lineSet) begin
         lsrPend <= 1'b1;
      end else if (rdLsr) begin
         lsrPend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive sources
   assign rxLevel = fifoEnabled ? (rxFifoCount >= rxTrig) : rxHoldFull;

   uifc_rx_timeout u_timeout (
      .clock(clock),
      .rst_n(rst_n),
      .bitTick(bitTick),
      .charBits(charBits),
      .armed(fifoEnabled && dataPresent),
      .restart(rxCharArrived || rdData),
      .expire(timeoutExpire)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         timeoutPend <= 1'b0;
      end else if (timeoutExpire) begin
         timeoutPend <= 1'b1;
      end else if (rdData || !fifoEnabled) begin
         timeoutPend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit source
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         txCountQ <= FIFO_EMPTY;
         txHoldEmptyQ <= 1'b1;
         reachedTrig <= 1'b0;
      end else begin
         txCountQ <= txFifoCount;
         txHoldEmptyQ <= txHoldEmpty;
         if (txFifoCount == FIFO_EMPTY) reachedTrig <= 1'b0;
         else if (txFifoCount >= txTrig) reachedTrig <= 1'b1;
      end
   end

   // empty fires alone only when the last reload never reached the level
   always_comb begin
      if (fifoEnabled) begin
         txSet = (txFifoCount < txTrig && txCountQ >= txTrig) ||
            (txFifoCount == FIFO_EMPTY && txCountQ != FIFO_EMPTY && !reachedTrig);
      end else begin
         txSet = txHoldEmpty && !txHoldEmptyQ;
      end
      if (wrIer && regWrData[IE_TX] && !intEnable[IE_TX] && txEmptyNow) txSet = 1'b1;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         txPend <= 1'b0;
      end else if (txSet) begin
         txPend <= 1'b1;
      end else if (wrData || (rdIsr && currentSrc == UIFC_SRC_TX_READY)) begin
         txPend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software and hardware flow sources
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         xoffPend <= 1'b0;
         specialPend <= 1'b0;
      end else begin
         if (xoffMatch) xoffPend <= 1'b1;
         else if (xonMatch || (rdIsr && currentSrc == UIFC_SRC_XOFF)) xoffPend <= 1'b0;
         if (specialMatch) specialPend <= 1'b1;
         else if (rxCharArrived || (rdIsr && currentSrc == UIFC_SRC_XOFF)) specialPend <= 1'b0;
      end
   end

   // three stages, a change counts once the last two agree
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctsSync1 <= 1'b1;
         ctsSync2 <= 1'b1;
         ctsSync3 <= 1'b1;
         ctsStable <= 1'b1;
         ctsStableQ <= 1'b1;
      end else begin
         ctsSync1 <= ctsPin_n;
         ctsSync2 <= ctsSync1;
         ctsSync3 <= ctsSync2;
         if (ctsSync2 == ctsSync3) ctsStable <= ctsSync3;
         ctsStableQ <= ctsStable;
      end
   end

   assign ctsRise = ctsStable && !ctsStableQ;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rtsPend <= 1'b0;
         ctsPend <= 1'b0;
      end else begin
         if (rtsRise && autoRtsEnable) rtsPend <= 1'b1;
         else if (rdMsr) rtsPend <= 1'b0;
         if (ctsRise && autoCtsEnable) ctsPend <= 1'b1;
         else if (rdMsr) ctsPend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // priority and read-back
   always_comb begin
      req[0] = intEnable[IE_LINE] && lsrPend;
      req[1] = intEnable[IE_RX] && timeoutPend;
      req[2] = intEnable[IE_RX] && rxLevel;
      req[3] = intEnable[IE_TX] && txPend;
      req[4] = intEnable[IE_MODEM] && (modemStatus[3:0] != 4'h0);
      req[5] = enhancedEnable && intEnable[IE_XOFF] && (xoffPend || specialPend);
      req[6] = enhancedEnable && ((intEnable[IE_RTS] && rtsPend) ||
         (intEnable[IE_CTS] && ctsPend));
   end

   assign currentSrc = pick_source(req);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= READ_IDLE;
      end else if (rdIsr) begin
         regRdData <= {fifoEnabled, fifoEnabled, currentSrc};
      end else if (rdLsr) begin
         regRdData <= {rxFifoAnyError && fifoEnabled, txEmptyNow && txShiftEmpty, txEmptyNow,
            dataPresent && frontBreak, dataPresent && frontFramingError,
            dataPresent && frontParityError, overrunFlag, dataPresent};
      end else if (rdMsr) begin
         regRdData <= modemStatus;
      end else if (regRead && regAddr == OFS_INT_ENABLE) begin
         regRdData <= intEnable;
      end else begin
         regRdData <= READ_IDLE;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irqOut <= 1'b0;
         irqOutEnable_n <= 1'b1;
      end else begin
         irqOut <= (currentSrc != UIFC_SRC_NONE);
         irqOutEnable_n <= !intDriveEnable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_isr_none_code: assert property (rdIsr && req == 7'h00 |=>
      regRdData[5:0] == 6'h01) else $error("idle status code wrong");
   a_isr_fifo_bits: assert property (rdIsr |=>
      regRdData[7:6] == {2{$past(fifoEnabled)}}) else $error("fifo bits wrong");
   a_ier_guarded: assert property (wrIer && !enhancedEnable |=>
      intEnable[7:4] == $past(intEnable[7:4])) else $error("upper enables changed");
   a_fcr_gated: assert property (wrFcr && !regWrData[FC_ENABLE] |=>
      !fifoEnabled && !rxFifoReset && dmaMode == $past(dmaMode)) else $error("fcr not gated");
   // back-to-back control writes may legally stretch the pulse
   a_reset_pulse: assert property ((rxFifoReset || txFifoReset) && !wrFcr |=>
      !rxFifoReset && !txFifoReset) else $error("fifo reset stuck");
   a_tx_enable_irq: assert property (wrIer && regWrData[IE_TX] && !intEnable[IE_TX] &&
      txEmptyNow |=> txPend) else $error("no transmit irq at enable");
   a_line_clears: assert property (rdLsr && !lineSet |=> !lsrPend)
      else $error("line irq not cleared");
   a_rx_priority: assert property (rdIsr && req[2] && req[1:0] == 2'h0 |=>
      regRdData[5:0] == 6'h04) else $error("receive priority wrong");
   a_irq_follows: assert property (##1 irqOut == $past(currentSrc != UIFC_SRC_NONE))
      else $error("irq pin mismatch");
   a_pin_drive: assert property (##1 irqOutEnable_n == !$past(intDriveEnable))
      else $error("pin enable mismatch");
   a_cts_sets: assert property (ctsRise && autoCtsEnable |=> ctsPend)
      else $error("cts edge lost");

   c_timeout_irq: cover property (timeoutExpire ##1 currentSrc == UIFC_SRC_TIMEOUT);
   c_tx_isr_clear: cover property (rdIsr && currentSrc == UIFC_SRC_TX_READY ##1 !txPend);
   c_cts_irq: cover property (ctsPend && currentSrc == UIFC_SRC_FLOW);
endmodule // uifc_irq_fifo_ctrl
`default_nettype wire

// ===== uifc_pkg.sv
`default_nettype none
package uifc_pkg;
   // register offsets on the 3-bit host port
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
   localparam logic [2:0] OFS_INT_STATUS = 3'h2;
   localparam logic [2:0] OFS_FIFO_CONTROL = 3'h2;
   localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
   localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;
   // interrupt_enable fields
   localparam int IE_RX = 0;
   localparam int IE_TX = 1;
   localparam int IE_LINE = 2;
   localparam int IE_MODEM = 3;
   localparam int IE_SLEEP = 4;
   localparam int IE_XOFF = 5;
   localparam int IE_RTS = 6;
   localparam int IE_CTS = 7;
   // fifo_control fields
   localparam int FC_ENABLE = 0;
   localparam int FC_RX_RESET = 1;
   localparam int FC_TX_RESET = 2;
   localparam int FC_DMA = 3;
   // reset values
   localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
   localparam logic [1:0] TRIG_CODE_RESET = 2'h0;
   localparam logic [4:0] FIFO_EMPTY = 5'h00;
   localparam logic [7:0] READ_IDLE = 8'h00;
   // receive time-out, in characters and extra bit times
   localparam int TIMEOUT_CHARS = 4;
   localparam int TIMEOUT_EXTRA_BITS = 12;
   // interrupt_status source codes, bits 5:0
   typedef enum logic [5:0] {
      UIFC_SRC_LINE = 6'h06,
      UIFC_SRC_TIMEOUT = 6'h0C,
      UIFC_SRC_RX_READY = 6'h04,
      UIFC_SRC_TX_READY = 6'h02,
      UIFC_SRC_MODEM = 6'h00,
      UIFC_SRC_XOFF = 6'h10,
      UIFC_SRC_FLOW = 6'h20,
      UIFC_SRC_NONE = 6'h01
   } uifc_src_t;

   function automatic logic [4:0] uifc_trig_level(input logic [1:0] code);
      case (code)
         2'h0: uifc_trig_level = 5'h01;
         2'h1: uifc_trig_level = 5'h04;
         2'h2: uifc_trig_level = 5'h08;
         default: uifc_trig_level = 5'h0E;
      endcase
   endfunction
endpackage
`default_nettype wire

// ===== uifc_rx_timeout.sv
`timescale 1ns/100ps
`default_nettype none
module uifc_rx_timeout (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // bit timing
   input wire logic bitTick,
   input wire logic [3:0] charBits,
   // control
   input wire logic armed,
   input wire logic restart,
   output logic expire
);
   import uifc_pkg::*;

   logic [6:0] bitCount;
   logic [6:0] limit;

   assign limit = 7'(TIMEOUT_CHARS * charBits + TIMEOUT_EXTRA_BITS);

   // counter parks at the limit so one idle stretch fires only once
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bitCount <= 7'h00;
      end else if (!armed || restart) begin
         bitCount <= 7'h00;
      end else if (bitTick && bitCount != limit) begin
         bitCount <= bitCount + 7'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         expire <= 1'b0;
      end else begin
         expire <= armed && !restart && bitTick && (bitCount == limit - 7'h01);
      end
   end

   a_expire_armed: assert property (@(posedge clock) disable iff (!rst_n)
      expire |-> $past(armed)) else $error("time-out fired while not armed");
endmodule // uifc_rx_timeout
`default_nettype wire
